// ==== pwrmon_cfg.svh ====
// Register map, field positions and reset values of the power monitor registers.
// Assumes inclusion by the package and the design modules only.
`ifndef PWRMON_CFG_SVH
`define PWRMON_CFG_SVH

// ------------------------------------------------------------
// Offsets
// ------------------------------------------------------------
`define PWRMON_OFS_CONTROL 12'h000
`define PWRMON_OFS_STATUS 12'h004
`define PWRMON_OFS_TRIM 12'h024

// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define PWRMON_THR_MSB 12
`define PWRMON_THR_LSB 9
`define PWRMON_EN_BIT 4
`define PWRMON_BELOW_BIT 2
`define PWRMON_CAL_MSB 9
`define PWRMON_CAL_LSB 5
`define PWRMON_SRC_MSB 4
`define PWRMON_SRC_LSB 0
`define PWRMON_SRC_USER 5'h1F
`define PWRMON_THR_MAX 4'hA

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PWRMON_THR_RESET 4'h3
`define PWRMON_EN_RESET 1'b0
`define PWRMON_STATUS_RESET 32'h0000_0000
`define PWRMON_CAL_DEFAULT 5'h0B

// AXI responses
`define PWRMON_RESP_OKAY 2'b00
`define PWRMON_RESP_SLVERR 2'b10

`endif

// ==== pwrmon_pkg.sv ====
// Types shared by the power monitor register modules.
// Assumes the constants header is in the include path.
`include "pwrmon_cfg.svh"

package pwrmon_pkg;
    typedef logic [31:0] pwrmon_word_t;
    typedef logic [3:0] pwrmon_thr_t;
    typedef logic [4:0] pwrmon_cal_t;

    // Settings software steers
    typedef struct packed {
        pwrmon_thr_t thr;
        logic en;
        pwrmon_cal_t user_cal;
        logic use_user;
    } pwrmon_ctl_s;
endpackage

// ==== pwrmon_sync.sv ====
// Two-stage synchroniser for the asynchronous comparator level.
// Assumes the input is a static level relative to aclk.
`timescale 1ns/1ps

module pwrmon_sync (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Level in and out
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic s1;
        logic s2;
    } pwrmon_sync_s;

    pwrmon_sync_s state_reg;
    pwrmon_sync_s state_next;

    always_comb begin
        state_next.s1 = async_in;
        state_next.s2 = state_reg.s1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.s2;
endmodule // pwrmon_sync

// ==== pwrmon_trim.sv ====
// Trim source selection for the slow internal oscillator.
// Assumes the factory value is a stable strap caught after reset release.
`timescale 1ns/1ps
`include "pwrmon_cfg.svh"

module pwrmon_trim (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Factory trim and software settings
    input wire logic [4:0] factory_cal,
    input wire logic [4:0] user_cal,
    input wire logic use_user,
    // Trim seen by software and by the oscillator
    output logic [4:0] default_cal,
    output logic [4:0] slow_osc_trim
);
    typedef struct packed {
        logic loaded;
        logic [4:0] cal;
        logic [4:0] trim;
    } pwrmon_trim_s;

    pwrmon_trim_s state_reg;
    pwrmon_trim_s state_next;

    always_comb begin
        state_next = state_reg;
        if (!state_reg.loaded) begin
            state_next.loaded = 1'b1;
            state_next.cal = factory_cal;
        end
        state_next.trim = use_user ? user_cal : state_next.cal;
    end

    // Strap is sampled by the clock after release, never by reset itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= {1'b0, `PWRMON_CAL_DEFAULT, `PWRMON_CAL_DEFAULT};
        end else begin
            state_reg <= state_next;
        end
    end

    assign default_cal = state_reg.cal;
    assign slow_osc_trim = state_reg.trim;
endmodule // pwrmon_trim

// ==== pwrmon_regs.sv ====
// AXI4-Lite register bank for the supply monitor and slow oscillator trim.
// Assumes a single aclk domain; comparator output arrives asynchronously.
//
// Overview of operation
// - Threshold select field bits 12:9, 1.8-4.8V
// - Control bit 4 turns monitor on
// - Status bit 2 flags supply below threshold
// - Below flag valid only while enabled
// - Reserved bits always read zero
// - Status at 0x04, resets to zero
// - Calibration field loads factory value at startup
// - Calibration field reads factory value, except 0x0B for a read on the first clock after reset release
// - Written calibration applies only when source 1F
// - Source field resets zero, reads zero
// - Other source values restore factory trim
`timescale 1ns/1ps
`include "pwrmon_cfg.svh"

module pwrmon_regs (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog monitor
    input wire logic monitor_below_async,
    output logic monitor_enable,
    output logic [3:0] monitor_threshold_select,
    // Slow oscillator trim
    input wire logic [4:0] factory_cal,
    output logic [4:0] slow_osc_trim_value
);
    typedef struct packed {
        // Write halves held until both are in
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        // Read answer, standing until rready
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        // Settings software steers
        pwrmon_pkg::pwrmon_ctl_s ctl;
    } pwrmon_regs_s;

    pwrmon_regs_s state_reg;
    pwrmon_regs_s state_next;

    logic below_sync;
    logic [4:0] default_cal;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Register picked by a word address; write and read decode share it
    typedef enum {
        sel_none,
        sel_control,
        sel_status,
        sel_trim
    } pwrmon_sel_e;

    function automatic pwrmon_sel_e decode_reg(input logic [11:0] addr);
        logic [11:0] word_addr;
        word_addr = {addr[11:2], 2'b00};
        case (word_addr)
            `PWRMON_OFS_CONTROL: begin
                decode_reg = sel_control;
            end
            `PWRMON_OFS_STATUS: begin
                decode_reg = sel_status;
            end
            `PWRMON_OFS_TRIM: begin
                decode_reg = sel_trim;
            end
            // Holes in the map answer with an error, never alias
            default: begin
                decode_reg = sel_none;
            end
        endcase
    endfunction

    // Response code decision
    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (decode_reg(addr) != sel_none);
    endfunction

    function automatic logic [31:0] control_image(input pwrmon_pkg::pwrmon_ctl_s ctl);
        logic [31:0] img;
        img = 32'h0000_0000;
        img[`PWRMON_THR_MSB:`PWRMON_THR_LSB] = ctl.thr;
        img[`PWRMON_EN_BIT] = ctl.en;
        control_image = img;
    endfunction

    function automatic logic [31:0] status_image(input logic below, input logic en);
        logic [31:0] img;
        img = `PWRMON_STATUS_RESET;
        img[`PWRMON_BELOW_BIT] = below & en;
        status_image = img;
    endfunction

    function automatic logic [31:0] trim_image(input logic [4:0] cal);
        logic [31:0] img;
        img = 32'h0000_0000;
        img[`PWRMON_CAL_MSB:`PWRMON_CAL_LSB] = cal;
        trim_image = img;
    endfunction

    // Per-lane merge; lanes without a strobe keep the old byte
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        merge = res;
    endfunction

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    pwrmon_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(monitor_below_async),
        .sync_out(below_sync)
    );

    // Trim path sees the stored settings one cycle after the write
    pwrmon_trim u_trim (
        .aclk(aclk),
        .aresetn(aresetn),
        .factory_cal(factory_cal),
        .user_cal(state_reg.ctl.user_cal),
        .use_user(state_reg.ctl.use_user),
        .default_cal(default_cal),
        .slow_osc_trim(slow_osc_trim_value)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] wr;
        logic [11:0] waddr;
        logic [31:0] wd;
        logic [3:0] ws;
        logic do_write;
        wr = '0;
        do_write = 1'b0;
        state_next = state_reg;
        waddr = state_reg.aw_held ? state_reg.aw_addr : s_axi_awaddr;
        wd = state_reg.w_held ? state_reg.w_data : s_axi_wdata;
        ws = state_reg.w_held ? state_reg.w_strb : s_axi_wstrb;

        // ------------------------------------------------------------
        // Write path
        // ------------------------------------------------------------
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        do_write = !state_reg.bvalid
            && (state_reg.aw_held || s_axi_awvalid)
            && (state_reg.w_held || s_axi_wvalid);
        if (s_axi_bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        if (do_write) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = is_mapped(waddr) ? `PWRMON_RESP_OKAY : `PWRMON_RESP_SLVERR;
            // Lanes merge over the current image so a partial write keeps the rest
            if (decode_reg(waddr) == sel_control) begin
                wr = merge(control_image(state_reg.ctl), wd, ws);
                state_next.ctl.thr = wr[`PWRMON_THR_MSB:`PWRMON_THR_LSB];
                state_next.ctl.en = wr[`PWRMON_EN_BIT];
            end
            // Status is read only: a write to it is answered and changes nothing
            if (decode_reg(waddr) == sel_trim) begin
                wr = merge(trim_image(state_reg.ctl.user_cal), wd, ws);
                state_next.ctl.user_cal = wr[`PWRMON_CAL_MSB:`PWRMON_CAL_LSB];
                // Source byte lane present: decide trim source
                if (ws[0]) begin
                    state_next.ctl.use_user = (wr[`PWRMON_SRC_MSB:`PWRMON_SRC_LSB] == `PWRMON_SRC_USER);
                end
            end
        end

        // ------------------------------------------------------------
        // Read path
        // ------------------------------------------------------------
        if (s_axi_rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            state_next.rvalid = 1'b1;
            state_next.rresp = `PWRMON_RESP_OKAY;
            state_next.rdata = '0;
            case (decode_reg(s_axi_araddr))
                sel_control: begin
                    state_next.rdata = control_image(state_reg.ctl);
                end
                sel_status: begin
                    state_next.rdata = status_image(below_sync, state_reg.ctl.en);
                end
                sel_trim: begin
                    state_next.rdata = trim_image(default_cal);
                end
                default: begin
                    state_next.rresp = `PWRMON_RESP_SLVERR;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
            state_reg.ctl.thr <= `PWRMON_THR_RESET;
            state_reg.ctl.en <= `PWRMON_EN_RESET;
            state_reg.ctl.use_user <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // One write in flight; new address/data wait until response accepted
    assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
    assign s_axi_wready = !state_reg.w_held && !state_reg.bvalid;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign monitor_enable = state_reg.ctl.en;
    assign monitor_threshold_select = state_reg.ctl.thr;
endmodule // pwrmon_regs

// ==== pwrmon_regs_monitor.sv ====
// Port checker of the power monitor register bank.
// Assumes one aclk domain; bound onto pwrmon_regs below.
`timescale 1ns/1ps

module pwrmon_regs_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // Monitor and trim
    input wire logic monitor_below_async,
    input wire logic monitor_enable,
    input wire logic [3:0] monitor_threshold_select,
    input wire logic [4:0] factory_cal,
    input wire logic [4:0] slow_osc_trim_value
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic wr;
    logic rd;
    assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign rd = s_axi_arvalid && s_axi_arready;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_thr; wr && s_axi_awaddr == 12'h000 && s_axi_wstrb[1] && s_axi_wdata[12:9] <= 4'hA
        |=> monitor_threshold_select == $past(s_axi_wdata[12:9]); endproperty
    a_thr: assert property (p_thr) else $error("threshold not taken");
    property p_en; wr && s_axi_awaddr == 12'h000 && s_axi_wstrb[0] |=> monitor_enable == $past(s_axi_wdata[4]);
    endproperty
    a_en: assert property (p_en) else $error("enable not taken");
    // Level must have settled for a while so the synchroniser has caught up
    property p_below; ($stable(monitor_below_async) && monitor_enable) [*5] ##0 (rd && s_axi_araddr == 12'h004)
        |=> s_axi_rdata[2] == $past(monitor_below_async); endproperty
    a_below: assert property (p_below) else $error("below flag wrong");
    property p_off; rd && s_axi_araddr == 12'h004 && !monitor_enable |=> s_axi_rdata == 32'h0000_0000; endproperty
    a_off: assert property (p_off) else $error("flag seen while off");
    property p_res; s_axi_rvalid |-> s_axi_rdata[31:13] == 19'h0_0000; endproperty
    a_res: assert property (p_res) else $error("reserved bits set");
    property p_trim_rd; rd && s_axi_araddr == 12'h024 && $past(aresetn, 3)
        |=> s_axi_rdata == {22'h00_0000, factory_cal, 5'h00}; endproperty
    a_trim_rd: assert property (p_trim_rd) else $error("trim readback wrong");
    property p_user; wr && s_axi_awaddr == 12'h024 && s_axi_wstrb[1:0] == 2'b11 && s_axi_wdata[4:0] == 5'h1F
        |-> ##3 slow_osc_trim_value == $past(s_axi_wdata[9:5], 3); endproperty
    a_user: assert property (p_user) else $error("user trim not applied");
    property p_fact; wr && s_axi_awaddr == 12'h024 && s_axi_wstrb[0] && s_axi_wdata[4:0] != 5'h1F
        |-> ##3 slow_osc_trim_value == factory_cal; endproperty
    a_fact: assert property (p_fact) else $error("factory trim not restored");
    // Two stages mean no level newer than two edges can reach a read
    property p_sync; rd && s_axi_araddr == 12'h004 && !$past(monitor_below_async, 2) |=> !s_axi_rdata[2];
    endproperty
    a_sync: assert property (p_sync) else $error("flag not synchronised");
    c_user: cover property (wr && s_axi_awaddr == 12'h024 && s_axi_wdata[4:0] == 5'h1F);
    c_low: cover property (s_axi_rvalid && s_axi_rdata[2]);
    c_en: cover property (wr && s_axi_awaddr == 12'h000 && s_axi_wdata[4]);
endmodule // pwrmon_regs_monitor

bind pwrmon_regs pwrmon_regs_monitor pwrmon_regs_monitor_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .monitor_below_async, .monitor_enable, .monitor_threshold_select, .factory_cal, .slow_osc_trim_value
);

// ==== tb_top.sv ====
// Self-checking bench of the power monitor register bank.
// Assumes design and checker are compiled before it.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb_top;
    localparam logic [4:0] fcal = 5'h15; // Arbitrary strap value
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, monitor_below_async = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, monitor_enable;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 0, monitor_threshold_select;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [4:0] slow_osc_trim_value;
    int n_errors = 0, check_count = 0, cyc = 0;

    pwrmon_regs pwrmon_regs_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .monitor_below_async, .monitor_enable, .monitor_threshold_select, .factory_cal(fcal),
        .slow_osc_trim_value
    );

    initial begin
        forever #25 aclk = ~aclk;
    end
    // A hung handshake ends the run here
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
        logic aw_ok, w_ok;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !aw_ok) || (s_axi_wvalid && !w_ok));
        do @(negedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rd(12'h000);
        `CHK("ctl_rst", 32'h0000_0600, d)
        rd(12'h004);
        `CHK("sts_rst", 32'h0000_0000, d)
        `CHK("sts_resp", 2'b00, r)
        rd(12'h024);
        `CHK("trim_rst", {22'h00_0000, fcal, 5'h00}, d)
    endtask
    // Reserved bits are written as ones on purpose
    task t_ctl;
        for (int i = 0; i <= 10; i++) begin
            wr(12'h000, {19'h7_FFFF, i[3:0], 9'h1FF}, 4'hF);
            rd(12'h000);
            `CHK("ctl", {19'h0_0000, i[3:0], 9'h010}, d)
            `CHK("thr_pin", i[3:0], monitor_threshold_select)
            `CHK("en_pin", 1'b1, monitor_enable)
        end
        wr(12'h000, 32'h0000_0A00, 4'hF);
        `CHK("ctl_bresp", 2'b00, r)
        rd(12'h000);
        `CHK("ctl_off", 32'h0000_0A00, d)
        `CHK("en_off", 1'b0, monitor_enable)
    endtask
    task t_status;
        monitor_below_async <= 1'b1;
        repeat (5) @(posedge aclk);
        rd(12'h004);
        `CHK("sts_off", 32'h0000_0000, d)
        wr(12'h000, 32'h0000_0010, 4'h1);
        repeat (5) @(posedge aclk);
        rd(12'h004);
        `CHK("sts_low", 32'h0000_0004, d)
        monitor_below_async <= 1'b0;
        repeat (5) @(posedge aclk);
        rd(12'h004);
        `CHK("sts_high", 32'h0000_0000, d)
        monitor_below_async <= 1'b1;
        rd(12'h004);
        `CHK("sts_sync", 32'h0000_0000, d)
    endtask
    task t_trim;
        wr(12'h024, {22'h3F_FFFF, 5'h07, 5'h1F}, 4'hF);
        rd(12'h024);
        `CHK("trim_rd", {22'h00_0000, fcal, 5'h00}, d)
        `CHK("trim_user", 5'h07, slow_osc_trim_value)
        wr(12'h024, {22'h00_0000, 5'h09, 5'h1E}, 4'hF);
        rd(12'h024);
        `CHK("trim_src", {22'h00_0000, fcal, 5'h00}, d)
        `CHK("trim_fact", fcal, slow_osc_trim_value)
        // Lane 1 is not strobed, so calibration bits 9:8 keep the stored value
        wr(12'h024, {22'h00_0000, 5'h19, 5'h1F}, 4'h1);
        rd(12'h024);
        `CHK("trim_user2", 5'h09, slow_osc_trim_value)
    endtask
    task t_unmap;
        wr(12'h010, 32'hFFFF_FFFF, 4'hF);
        `CHK("unmap_b", 2'b10, r)
        rd(12'h010);
        `CHK("unmap_d", 32'h0000_0000, d)
        `CHK("unmap_r", 2'b10, r)
    endtask
    // Reset in mid-run with the user trim selected and the monitor on
    task t_midreset;
        wr(12'h024, {22'h00_0000, 5'h07, 5'h1F}, 4'hF);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK("trim_rst2", fcal, slow_osc_trim_value)
        `CHK("en_rst2", 1'b0, monitor_enable)
        rd(12'h000);
        `CHK("ctl_rst2", 32'h0000_0600, d)
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_ctl();
        t_status();
        t_trim();
        t_unmap();
        t_midreset();
        report_and_stop();
    end
endmodule // tb_top
